/* File: rtl/dac_ctrl.sv */
/*
 * Two-wire slave port with code and setup registers driving an 8-bit converter.
 * Assumes an open-drain data pin resolved outside and a host clock under 100 kHz.
 */
// How it works
// R1 - Converter code register is exactly eight bits.
// R2 - Host reaches a code and a setup register.
// R3 - Both analog outputs follow the code register.
// R4 - Data pin is shared, driven low when sending.
// R5 - Host clock is input only, paces shifting.
// R6 - Host enters standby by writing setup register.
// R7 - Standby bit zero is normal, one standby.
// R8 - Standby freezes converter output updates.
// R9 - Serial port keeps working during standby.
// R10 - Acknowledge only a matching seven-bit address.
// R11 - Eighth address bit one reads, zero writes.
// R12 - Ninth clock carries the receiver acknowledge.
// R13 - Every byte moves most significant bit first.
// R14 - Reset clears standby bit and code register.
module dac_ctrl #(
    parameter int code_w = dac_pkg::CODE_W
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic [code_w-1:0] dac_code,
    output logic standby_select_bit
);
    import dac_pkg::*;

    // The byte-wide code register feeds the converter through the level register. [R1]
    generate
        if (code_w != CODE_W) begin : g_bad_width
            $error("dac_ctrl: code_w must be 8");
        end
    endgenerate

    link_if lk ();

    link_front u_front (
        .core_clk(core_clk),
        .nrst(nrst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .lk(lk)
    );

    port_state_t state_r, state_nxt;
    logic [3:0] cnt_r;
    byte_t shift_r, tx_r, ptr_r, code_r, setup_r;
    logic [code_w-1:0] level_r;
    logic nack_r, oe_n_r, out_r;

    // Decode of bit positions and the byte just received.
    wire busy = state_r != ST_IDLE;
    wire bit_rise = lk.rise && busy && cnt_r < ACK_SLOT; // [R5]
    wire ack_rise = lk.rise && busy && cnt_r == ACK_SLOT;
    wire byte_end = lk.fall && busy && cnt_r == LAST_BIT;
    wire ack_end = lk.fall && busy && cnt_r == ACK_SLOT;
    wire byte_t rx_byte = shift_r;
    wire addr_hit = rx_byte[7:1] == SLAVE_ADDR;
    wire ack_nxt = (state_r == ST_ADDR && addr_hit) || state_r == ST_CMD || state_r == ST_WDATA;
    wire wr_code = byte_end && state_r == ST_WDATA && ptr_r == CMD_CODE_REG;
    wire wr_setup = byte_end && state_r == ST_WDATA && ptr_r == CMD_SETUP_REG;
    wire byte_t rd_sel = (ptr_r == CMD_SETUP_REG) ? setup_r :
                         (ptr_r == CMD_CODE_REG) ? code_r : 8'h00;
    wire load_tx = ack_end && state_r == ST_RDATA && !nack_r;
    wire tx_step = lk.fall && state_r == ST_RDATA && cnt_r < LAST_BIT;
    wire standby = setup_r[STANDBY_POS];

    // Protocol sequencing; stop beats start only when both land together.
    always_comb begin
        state_nxt = state_r;
        if (lk.stop) begin
            state_nxt = ST_IDLE;
        end else if (lk.start) begin
            state_nxt = ST_ADDR;
        end else if (byte_end) begin
            case (state_r)
                ST_ADDR: begin
                    // A foreign address sends the port back to waiting. [R10]
                    if (!addr_hit) begin
                        state_nxt = ST_IDLE;
                    end else if (rx_byte[0]) begin
                        state_nxt = ST_RDATA; // [R11]
                    end else begin
                        state_nxt = ST_CMD; // [R11]
                    end
                end
                ST_CMD: state_nxt = ST_WDATA;
                default: state_nxt = state_r;
            endcase
        end else if (ack_end && state_r == ST_RDATA && nack_r) begin
            state_nxt = ST_IDLE; // Host declined more data.
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Bit counter; ARMED swallows the clock fall that follows a start.
    always_ff @(posedge core_clk) begin
        if (!nrst || lk.start) begin
            cnt_r <= ARMED;
        end else if (lk.fall && busy) begin
            cnt_r <= (cnt_r == ACK_SLOT) ? 4'h0 : cnt_r + 4'h1;
        end
    end

    // Receive shifter fills from the low end, so the first bit lands on top. [R13]
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            shift_r <= 8'h00;
            nack_r <= 1'b0;
        end else begin
            if (bit_rise) begin
                shift_r <= {shift_r[6:0], lk.sda};
            end
            if (ack_rise) begin
                nack_r <= lk.sda; // [R12]
            end
        end
    end

    // Pin driver: pulls low for acknowledge and zero data bits, else lets go. [R4]
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            oe_n_r <= 1'b1;
            out_r <= 1'b0;
            tx_r <= 8'h00;
        end else begin
            out_r <= 1'b0;
            if (lk.start || lk.stop) begin
                oe_n_r <= 1'b1;
            end else if (byte_end) begin
                // Receiver acknowledges on the ninth clock; reads let the host answer. [R12]
                oe_n_r <= (state_r == ST_RDATA) ? 1'b1 : !ack_nxt;
            end else if (load_tx) begin
                oe_n_r <= rd_sel[7]; // [R13]
                tx_r <= {rd_sel[6:0], 1'b0};
            end else if (ack_end) begin
                oe_n_r <= 1'b1; // [R12]
            end else if (tx_step) begin
                oe_n_r <= tx_r[7]; // [R13]
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end
    end

    // Register file; writes land in standby too, since the port never stops. [R2] [R9]
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            code_r <= CODE_RESET; // [R14]
            setup_r <= SETUP_RESET; // [R14]
            ptr_r <= CMD_CODE_REG;
        end else begin
            if (byte_end && state_r == ST_CMD) begin
                ptr_r <= rx_byte;
            end
            if (wr_code) begin
                code_r <= rx_byte; // [R1]
            end
            if (wr_setup) begin
                setup_r <= rx_byte & SETUP_MASK; // [R7]
            end
        end
    end

    // The converter level freezes in standby, so no supply is spent slewing. [R8]
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            level_r <= '0;
        end else if (!standby) begin
            level_r <= code_r[code_w-1:0]; // [R3]
        end
    end

    // One level word feeds the buffered and the unbuffered analog paths. [R3]
    assign dac_code = level_r;
    assign standby_select_bit = setup_r[STANDBY_POS]; // [R7]
    assign sda_oe_n = oe_n_r;
    assign sda_out = out_r;

    chk_code_write: assert property (@(posedge core_clk) disable iff (!nrst) // [R1]
        wr_code |=> code_r == $past(rx_byte))
        else $error("code register missed a write");

    chk_setup_write: assert property (@(posedge core_clk) disable iff (!nrst) // [R2]
        wr_setup |=> standby_select_bit == $past(rx_byte[0]))
        else $error("setup register missed a write");

    chk_level_follow: assert property (@(posedge core_clk) disable iff (!nrst) // [R3]
        !standby |=> dac_code == $past(code_r))
        else $error("converter level lags the code register");

    chk_standby_freeze: assert property (@(posedge core_clk) disable iff (!nrst) // [R8]
        standby |=> $stable(dac_code))
        else $error("converter level moved in standby");

    chk_addr_ack: assert property (@(posedge core_clk) disable iff (!nrst) // [R10]
        byte_end && state_r == ST_ADDR |=> sda_oe_n == !$past(addr_hit))
        else $error("address acknowledge wrong");

    chk_read_dir: assert property (@(posedge core_clk) disable iff (!nrst) // [R11]
        byte_end && state_r == ST_ADDR && addr_hit && !lk.start && !lk.stop
        |=> state_r == ($past(rx_byte[0]) ? ST_RDATA : ST_CMD))
        else $error("direction bit ignored");

    chk_ack_release: assert property (@(posedge core_clk) disable iff (!nrst) // [R12]
        ack_end && state_r != ST_RDATA |=> sda_oe_n)
        else $error("data line held after acknowledge");

    chk_msb_first: assert property (@(posedge core_clk) disable iff (!nrst) // [R13]
        load_tx |=> sda_oe_n == $past(rd_sel[7]))
        else $error("read byte not sent msb first");

    chk_reset_clear: assert property (@(posedge core_clk) // [R14]
        !nrst |=> code_r == CODE_RESET && !standby_select_bit)
        else $error("reset left registers set");
endmodule

/* File: rtl/dac_pkg.sv */
/*
 * Shared constants and types for the two-wire converter control block.
 * Assumes a 40 MHz core clock far faster than the 100 kHz serial clock.
 */
package dac_pkg;
    typedef logic [7:0] byte_t;
    localparam int CODE_W = 8;
    localparam logic [6:0] SLAVE_ADDR = 7'h48;
    localparam byte_t CMD_CODE_REG = 8'h00;
    localparam byte_t CMD_SETUP_REG = 8'h01;
    localparam int STANDBY_POS = 0;
    localparam byte_t SETUP_MASK = 8'h01;
    localparam byte_t CODE_RESET = 8'h00;
    localparam byte_t SETUP_RESET = 8'h00;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] ARMED = 4'hF;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_CMD = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100
    } port_state_t;
endpackage

/* File: rtl/link_if.sv */
/*
 * Carrier for the conditioned serial line events between front end and core.
 * Assumes both ends run on core_clk.
 */
interface link_if;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic sda;
    modport front (output rise, output fall, output start, output stop, output sda);
    modport core (input rise, input fall, input start, input stop, input sda);
endinterface

/* File: rtl/link_front.sv */
/*
 * Synchronises the serial clock and data pins and finds edges and bus conditions.
 * Assumes the pins are asynchronous to core_clk and change slowly against it.
 */
module link_front (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    link_if.front lk
);
    logic scl_m_r, scl_s_r, scl_d_r;
    logic sda_m_r, sda_s_r, sda_d_r;

    // Two stages against metastability, then one more stage for edge finding.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_m_r <= scl_in;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= sda_in;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
        end
    end

    // Edges of the host clock; data moves only on these. [R5]
    assign lk.rise = scl_s_r & ~scl_d_r;
    assign lk.fall = ~scl_s_r & scl_d_r;
    // Data changing while the clock is high marks start or stop.
    assign lk.start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
    assign lk.stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
    assign lk.sda = sda_s_r;
endmodule

/* File: bench/host_model.sv */
/*
 * Behavioural two-wire host that clocks bytes into and out of the converter port.
 * Assumes an open-drain data wire with a pull-up resolved by the bench.
 */
module host_model
    import dac_pkg::*;
(
    input wire logic core_clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_drv
);
    timeunit 1ns;
    timeprecision 100ps;

    // The bus idles high on both wires.
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // The leading pause keeps the data change apart from the last clock fall.
    task automatic start();
        tick(2);
        sda_drv <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_drv <= 1'b0;
        tick(4);
        scl <= 1'b0;
    endtask

    task automatic stop();
        tick(2);
        sda_drv <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_drv <= 1'b1;
        tick(8);
    endtask

    // One 200 ns cell: data set in the low half, wire sampled in the high half.
    task automatic bit_cell(input logic b, output logic s);
        tick(2);
        sda_drv <= b;
        tick(2);
        scl <= 1'b1;
        tick(2);
        s = sda_wire;
        tick(2);
        scl <= 1'b0;
    endtask

    // Returns ack low when the device pulled the wire in the ninth cell.
    task automatic send_byte(input byte_t d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cell(d[i], s);
        bit_cell(1'b1, ack);
    endtask

    // Host answers with nack on the last byte so the device lets go.
    task automatic recv_byte(input logic last, output byte_t d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cell(1'b1, s);
            d[i] = s;
        end
        bit_cell(last, s);
    endtask
endmodule

/* File: bench/serial_dac_register_control_test.sv */
/*
 * Self-checking bench for the converter control port against a register model.
 * Assumes the host model drives the pins and the data wire has a pull-up.
 */
module serial_dac_register_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    import dac_pkg::*;

    logic core_clk;
    logic nrst = 1'b0;
    logic scl, sda_drv, sda_oe_n, sda_out, stby;
    logic sda_wire;
    logic [7:0] dac_code;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    int code_m = 0;
    int setup_m = 0;
    int out_m = 0;
    byte_t d;
    logic [6:0] bad;

    // Open-drain wire: low if either party pulls, pull-up otherwise.
    assign sda_wire = sda_drv & (sda_oe_n | sda_out);

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    host_model host (.core_clk(core_clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));

    dac_ctrl dut (
        .core_clk(core_clk),
        .nrst(nrst),
        .scl_in(scl),
        .sda_in(sda_wire),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .dac_code(dac_code),
        .standby_select_bit(stby)
    );

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t byte got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t bit got %h expected %h", $time, got, exp);
        end
    endtask

    // Register write transaction; the model follows only a matching address.
    task automatic wr(input logic [6:0] addr, input byte_t cmd, input byte_t val);
        logic a;
        host.start();
        host.send_byte({addr, 1'b0}, a);
        check_bit(a, addr != SLAVE_ADDR);
        if (addr == SLAVE_ADDR) begin
            host.send_byte(cmd, a);
            check_bit(a, 1'b0);
            host.send_byte(val, a);
            check_bit(a, 1'b0);
            if (cmd == CMD_CODE_REG) code_m = val;
            if (cmd == CMD_SETUP_REG) setup_m = val & SETUP_MASK;
        end
        host.stop();
        check_bit(sda_out, 1'b0);
        if (setup_m[STANDBY_POS] == 1'b0) out_m = code_m;
        check_byte(dac_code, out_m[7:0]);
        check_bit(stby, setup_m[STANDBY_POS]);
    endtask

    // Command write, repeated start, then two bytes read back from one register.
    // The host acknowledges the first byte, so the second must repeat it.
    task automatic rd(input byte_t cmd, output byte_t val);
        logic a;
        byte_t again;
        host.start();
        host.send_byte({SLAVE_ADDR, 1'b0}, a);
        check_bit(a, 1'b0);
        host.send_byte(cmd, a);
        check_bit(a, 1'b0);
        host.start();
        host.send_byte({SLAVE_ADDR, 1'b1}, a);
        check_bit(a, 1'b0);
        host.recv_byte(1'b0, val);
        host.recv_byte(1'b1, again);
        host.stop();
        check_byte(again, val);
    endtask

    // Cuts a hung run short well beyond the expected few thousand cycles.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        void'($urandom(56441));
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        check_byte(dac_code, CODE_RESET);
        check_bit(stby, 1'b0);
        repeat (4) wr(SLAVE_ADDR, CMD_CODE_REG, byte_t'($urandom));
        wr(SLAVE_ADDR, CMD_CODE_REG, 8'hFF);
        bad = 7'($urandom);
        if (bad == SLAVE_ADDR) bad = bad ^ 7'h01;
        wr(bad, CMD_CODE_REG, 8'h00);
        wr(SLAVE_ADDR, 8'h05, 8'h3C);
        rd(CMD_CODE_REG, d);
        check_byte(d, code_m[7:0]);
        wr(SLAVE_ADDR, CMD_SETUP_REG, 8'hFF);
        wr(SLAVE_ADDR, CMD_CODE_REG, byte_t'($urandom));
        rd(CMD_CODE_REG, d);
        check_byte(d, code_m[7:0]);
        rd(CMD_SETUP_REG, d);
        check_byte(d, setup_m[7:0]);
        rd(8'h05, d);
        check_byte(d, 8'h00);
        wr(SLAVE_ADDR, CMD_SETUP_REG, 8'h00);
        final_report();
    end
endmodule
